// [hdl/phase_offset_pkg.sv]
// Package: register map, reset values and ramp timing of the output phase offset block
// Assumes a 32-bit APB slave on ref_clk at 40 MHz
package phase_offset_pkg;
  // Register indices: byte address is index times four
  localparam logic [7:0] buildout_trim_index = 8'h72;
  localparam logic [7:0] shift_low_index = 8'h70;
  localparam logic [7:0] shift_high_index = 8'h71;
  localparam logic [7:0] ctrl_index = 8'h7c;
  localparam logic [7:0] status_index = 8'h7d;
  localparam logic [11:0] buildout_trim_addr = {2'b00, buildout_trim_index, 2'b00};
  localparam logic [11:0] shift_low_addr = {2'b00, shift_low_index, 2'b00};
  localparam logic [11:0] shift_high_addr = {2'b00, shift_high_index, 2'b00};
  localparam logic [11:0] ctrl_addr = {2'b00, ctrl_index, 2'b00};
  localparam logic [11:0] status_addr = {2'b00, status_index, 2'b00};
  localparam logic [5:0] buildout_trim_reset = 6'h00;
  localparam logic [15:0] shift_reset = 16'h0000;
  localparam logic [1:0] ctrl_reset = 2'h0;
  localparam int ctrl_ramp_off_bit = 0;
  localparam int ctrl_buildout_en_bit = 1;
  localparam int status_ramping_bit = 0;
  // One step is 1/2048 of the 77.76 MHz period
  localparam int steps_per_period = 2048;
  localparam logic [15:0] half_period_steps = 16'h0400;
  // Picoseconds per step, times 1000
  localparam int step_fs = 6279;
  // Ramp advances one step per interval
  localparam int ramp_interval_ns = 1000;
  localparam int clk_period_ns = 25;
  localparam int ramp_interval_cycles = (ramp_interval_ns + clk_period_ns - 1) / clk_period_ns;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_ramp = 2'b01
  } ramp_state_type;
endpackage

// [hdl/phase_ramp.sv]
// Ramp engine: walks the applied offset one step at a time toward a target
// Assumes target is stable or may change at any time
`timescale 1ns/100ps
module phase_ramp #(
  parameter int interval = 40
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [15:0] target,
  input wire logic bypass,
  output logic [15:0] applied,
  output logic busy
);
  import phase_offset_pkg::*;
  logic [15:0] applied_r;
  logic [15:0] applied_nxt;
  logic [15:0] tick_r;
  ramp_state_type state_r;
  wire tick = (tick_r == 16'(interval - 1));
  wire differs = (applied_r != target);
  wire below = $signed(applied_r) < $signed(target);
  assign applied = applied_r;
  assign busy = (state_r == st_ramp);
  always_comb begin
    applied_nxt = applied_r;
    if (bypass) begin
      applied_nxt = target;
    end else if (state_r == st_ramp && tick && differs) begin
      applied_nxt = below ? applied_r + 16'h0001 : applied_r - 16'h0001;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      applied_r <= shift_reset;
      tick_r <= 16'h0000;
      state_r <= st_idle;
    end else begin
      applied_r <= applied_nxt;
      tick_r <= (tick || state_r != st_ramp) ? 16'h0000 : tick_r + 16'h0001;
      case (state_r)
        st_idle: state_r <= (differs && !bypass) ? st_ramp : st_idle;
        st_ramp: state_r <= (bypass || applied_nxt == target) ? st_idle : st_ramp;
        default: state_r <= st_idle;
      endcase
    end
  end
endmodule

// [hdl/phase_offset_ctrl.sv]
// Output phase offset control: APB registers, offset ramp and build-out trim
// Assumes APB master on ref_clk; lock and build-out state come from the loop
//
// What this block does
// - Upper and lower offset bytes form one 16-bit signed offset.
// - Applied offset in picoseconds equals offset times 6.279.
// - Offset rewritten while locked ramps gradually toward the new value.
// - A control bit disables ramping, for changes made only in holdover.
// - With phase build-out enabled the programmed offset has no effect.
// - One offset step is 1/2048 of the 77.76 MHz period.
// - Offset 1024 shifts half a period, inverting the internal clock.
// - Signed 6-bit trim is added to every build-out event.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
module phase_offset_ctrl #(
  parameter int ramp_cycles = phase_offset_pkg::ramp_interval_cycles
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pll_locked,
  input wire logic buildout_event,
  output logic [15:0] applied_phase_shift,
  output logic [10:0] phase_within_period,
  output logic clock_inverted,
  output logic ramp_active,
  output logic [5:0] buildout_trim_value,
  output logic buildout_trim_strobe
);
  import phase_offset_pkg::*;
  // ==========================================================
  // Registers
  logic [7:0] shift_low_r;
  logic [7:0] shift_high_r;
  logic [5:0] trim_r;
  logic [1:0] ctrl_r;
  logic [5:0] trim_out_r;
  logic strobe_r;
  logic [15:0] eff_r;
  logic [15:0] ramp_applied;
  logic ramp_busy;
  // ==========================================================
  // Bus decode
  wire access = psel && penable;
  wire wr = access && pwrite;
  function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
    return a == reg_addr;
  endfunction
  wire hit_low = hit(paddr, shift_low_addr);
  wire hit_high = hit(paddr, shift_high_addr);
  wire hit_trim = hit(paddr, buildout_trim_addr);
  wire hit_ctrl = hit(paddr, ctrl_addr);
  wire hit_stat = hit(paddr, status_addr);
  wire mapped = hit_low || hit_high || hit_trim || hit_ctrl || hit_stat;
  wire ro_write = hit_stat && pwrite;
  wire [15:0] shift_word = {shift_high_r, shift_low_r};
  wire ramp_off = ctrl_r[ctrl_ramp_off_bit];
  wire buildout_en = ctrl_r[ctrl_buildout_en_bit];
  // Ramp only when locked and ramping is enabled
  wire bypass = ramp_off || !pll_locked;
  // Build-out enabled: programmed offset ignored
  wire [15:0] target = buildout_en ? shift_reset : shift_word;
  assign pready = 1'b1;
  assign pslverr = access && (!mapped || ro_write);
  // ==========================================================
  // Register writes
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      shift_low_r <= shift_reset[7:0];
      shift_high_r <= shift_reset[15:8];
      trim_r <= buildout_trim_reset;
      ctrl_r <= ctrl_reset;
    end else if (wr) begin
      if (hit_low) begin
        shift_low_r <= pwdata[7:0];
      end
      if (hit_high) begin
        shift_high_r <= pwdata[7:0];
      end
      if (hit_trim) begin
        trim_r <= pwdata[5:0];
      end
      if (hit_ctrl) begin
        ctrl_r <= pwdata[1:0];
      end
    end
  end
  // ==========================================================
  // Read data
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_low) begin
      rd_mux = {24'h00_0000, shift_low_r};
    end else if (hit_high) begin
      rd_mux = {24'h00_0000, shift_high_r};
    end else if (hit_trim) begin
      rd_mux = {26'h000_0000, trim_r};
    end else if (hit_ctrl) begin
      rd_mux = {30'h0000_0000, ctrl_r};
    end else if (hit_stat) begin
      rd_mux = {31'h0000_0000, ramp_busy};
    end
  end
  assign prdata = rd_mux;
  // ==========================================================
  // Ramp engine
  phase_ramp #(
    .interval(ramp_cycles)
  ) u_ramp (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .target(target),
    .bypass(bypass),
    .applied(ramp_applied),
    .busy(ramp_busy)
  );
  // ==========================================================
  // Outputs: step of 1/2048 period, about 6.279 ps at nominal rate
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      eff_r <= shift_reset;
      trim_out_r <= buildout_trim_reset;
      strobe_r <= 1'b0;
    end else begin
      eff_r <= ramp_applied;
      trim_out_r <= trim_r;
      strobe_r <= buildout_event;
    end
  end
  assign applied_phase_shift = eff_r;
  // Low 11 bits: position within one period of 2048 steps
  assign phase_within_period = eff_r[10:0];
  // Bit 10 set means at least half a period: clock inverted
  assign clock_inverted = eff_r[10];
  assign ramp_active = ramp_busy;
  assign buildout_trim_value = trim_out_r;
  assign buildout_trim_strobe = strobe_r;
endmodule

// [tb/phase_offset_monitor.sv]
// Checker: port-level assertions for the phase offset block
// Assumes binding onto phase_offset_ctrl, one clock domain
`timescale 1ns/100ps
module phase_offset_monitor (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pll_locked,
  input wire logic buildout_event,
  input wire logic [15:0] applied_phase_shift,
  input wire logic [10:0] phase_within_period,
  input wire logic clock_inverted,
  input wire logic ramp_active,
  input wire logic [5:0] buildout_trim_value,
  input wire logic buildout_trim_strobe
);
  import phase_offset_pkg::*;
  // ==========
  // Assertions
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_inv; clock_inverted == applied_phase_shift[10]; endproperty
  a_inv: assert property (p_inv) else $error("inversion flag wrong");
  property p_within; phase_within_period == applied_phase_shift[10:0]; endproperty
  a_within: assert property (p_within) else $error("phase within period wrong");
  property p_strobe_on; buildout_event |=> buildout_trim_strobe; endproperty
  a_strobe_on: assert property (p_strobe_on) else $error("trim strobe missing");
  property p_strobe_off; !buildout_event |=> !buildout_trim_strobe; endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("trim strobe spurious");
  property p_trim_copy; psel && penable && pwrite && paddr == buildout_trim_addr |-> ##2
    buildout_trim_value == $past(pwdata[5:0], 2); endproperty
  a_trim_copy: assert property (p_trim_copy) else $error("trim not applied");
  property p_trim_read; psel && penable && !pwrite && paddr == buildout_trim_addr |->
    prdata[31:6] == 26'h000_0000; endproperty
  a_trim_read: assert property (p_trim_read) else $error("trim upper bits set");
  property p_step; ramp_active |=> (applied_phase_shift - $past(applied_phase_shift))
    inside {16'h0000, 16'h0001, 16'hffff}; endproperty
  a_step: assert property (p_step) else $error("ramp jumped");
  property p_unlock; !pll_locked [*2] |-> !ramp_active; endproperty
  a_unlock: assert property (p_unlock) else $error("ramp while unlocked");
endmodule
bind phase_offset_ctrl phase_offset_monitor mon (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pll_locked(pll_locked),
  .buildout_event(buildout_event),
  .applied_phase_shift(applied_phase_shift),
  .phase_within_period(phase_within_period),
  .clock_inverted(clock_inverted),
  .ramp_active(ramp_active),
  .buildout_trim_value(buildout_trim_value),
  .buildout_trim_strobe(buildout_trim_strobe)
);

// [tb/tb_top.sv]
// Bench: directed scenarios for the phase offset block over APB
// Assumes ramp_cycles of 2 and a zero-wait slave
`timescale 1ns/100ps
module tb_top;
  import phase_offset_pkg::*;
  // ==========
  // Stimulus and checks
  logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic pll_locked = 0, buildout_event = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic err;
  logic pready, pslverr, clock_inverted, ramp_active, buildout_trim_strobe;
  logic [15:0] applied_phase_shift;
  logic [10:0] phase_within_period;
  logic [5:0] buildout_trim_value;
  int failures = 0, samples_checked = 0;
  localparam int ramp_cyc = 2;
  phase_offset_ctrl #(
    .ramp_cycles(ramp_cyc)
  ) uut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .pll_locked(pll_locked),
    .buildout_event(buildout_event),
    .applied_phase_shift(applied_phase_shift),
    .phase_within_period(phase_within_period),
    .clock_inverted(clock_inverted),
    .ramp_active(ramp_active),
    .buildout_trim_value(buildout_trim_value),
    .buildout_trim_strobe(buildout_trim_strobe)
  );
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic t_bypass;
    xfer(0, buildout_trim_addr, 0);
    chk(r, 0);
    chk(err, 0);
    xfer(1, shift_low_addr, 32'h0000_0000);
    xfer(1, shift_high_addr, 32'h0000_0004);
    repeat (3) @(posedge ref_clk);
    chk(applied_phase_shift, half_period_steps);
    chk(clock_inverted, 1);
    xfer(0, shift_high_addr, 0);
    chk(r, 32'h0000_0004);
  endtask
  task automatic t_ramp;
    int n;
    n = 0;
    pll_locked <= 1;
    xfer(1, shift_low_addr, 32'h0000_0003);
    repeat (2) @(posedge ref_clk);
    chk(ramp_active, 1);
    chk(applied_phase_shift, half_period_steps);
    while (ramp_active && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n, 3 * ramp_cyc);
    repeat (2) @(posedge ref_clk);
    chk(applied_phase_shift, 16'h0403);
    chk(phase_within_period, 11'h403);
    xfer(1, shift_low_addr, 32'h0000_0013);
    xfer(0, status_addr, 0);
    chk(r, 1);
    chk(err, 0);
    pll_locked <= 0;
    repeat (3) @(posedge ref_clk);
    chk(applied_phase_shift, 16'h0413);
    chk(ramp_active, 0);
  endtask
  task automatic t_off;
    pll_locked <= 1;
    xfer(1, ctrl_addr, 32'h0000_0001);
    xfer(1, shift_high_addr, 32'h0000_00ff);
    repeat (3) @(posedge ref_clk);
    chk(applied_phase_shift, 16'hff13);
    chk(ramp_active, 0);
    chk(phase_within_period, 11'h713);
    chk(clock_inverted, 1);
  endtask
  task automatic t_bo;
    xfer(1, ctrl_addr, 32'h0000_0003);
    repeat (3) @(posedge ref_clk);
    chk(applied_phase_shift, 0);
    xfer(1, buildout_trim_addr, 32'h0000_00ea);
    xfer(0, buildout_trim_addr, 0);
    chk(r, 32'h0000_002a);
    chk(buildout_trim_value, 6'h2a);
    buildout_event <= 1;
    @(posedge ref_clk);
    buildout_event <= 0;
    #1 chk(buildout_trim_strobe, 1);
    xfer(1, status_addr, 32'h0000_0001);
    chk(err, 1);
    xfer(0, 12'hffc, 0);
    chk(r, 0);
    chk(err, 1);
  endtask
  task automatic t_reset;
    xfer(1, ctrl_addr, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    chk(applied_phase_shift, 16'hff13);
    reset_n <= 0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1;
    @(posedge ref_clk);
    chk(applied_phase_shift, shift_reset);
    chk(buildout_trim_value, buildout_trim_reset);
    chk(ramp_active, 0);
    xfer(0, shift_high_addr, 0);
    chk(r, shift_reset[15:8]);
    xfer(0, ctrl_addr, 0);
    chk(r, ctrl_reset);
  endtask
  task automatic close_out;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1;
    t_bypass;
    t_ramp;
    t_off;
    t_bo;
    t_reset;
    close_out;
  end
  initial begin
    #100000;
    failures++;
    close_out;
  end
endmodule
